//--- src/epp_pkg.sv
// package for the enhanced parallel port block: offsets, fields, reset values, timing
// assumes a 10 MHz core clock
package epp_pkg;
  localparam logic [2:0] OFS_DATA = 3'h0;
  localparam logic [2:0] OFS_STATUS = 3'h1;
  localparam logic [2:0] OFS_CONTROL = 3'h2;
  localparam logic [2:0] OFS_ADDRESS = 3'h3;
  localparam logic [2:0] OFS_BYTE0 = 3'h4;
  localparam logic [2:0] OFS_BYTE1 = 3'h5;
  localparam logic [2:0] OFS_BYTE2 = 3'h6;
  localparam logic [2:0] OFS_BYTE3 = 3'h7;
  localparam int ST_TIMEOUT = 0;
  localparam int ST_IRQ = 2;
  localparam int ST_BUSY = 7;
  localparam int CT_STROBE = 0;
  localparam int CT_AUTOFD = 1;
  localparam int CT_INIT = 2;
  localparam int CT_SELIN = 3;
  localparam int CT_IRQ_EN = 4;
  localparam int CT_DIR = 5;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [7:0] CONTROL_RESET = 8'h04;
  localparam logic [7:0] ADDRESS_RESET = 8'h00;
  localparam logic [1:0] STATUS_FIXED_ONES = 2'h3;
  localparam int CLK_HZ = 10000000;
  localparam int TIMEOUT_US = 10;
  localparam int TIMEOUT_CYCLES = (TIMEOUT_US * (CLK_HZ / 1000000));
  typedef enum logic [2:0] {
    EPP_IDLE = 3'b000,
    EPP_SETUP = 3'b001,
    EPP_STROBE = 3'b010,
    EPP_WAIT_END = 3'b011,
    EPP_REL_STB = 3'b100,
    EPP_REL_ZWS = 3'b101,
    EPP_REL_DIR = 3'b110
  } epp_state_e;
endpackage

//--- src/epp_port.sv
// enhanced parallel port, revision 1.7 handshake, eight byte registers
// assumes synchronous host strobes, host ready open drain, core clock always running
//
// Summary of operation
// - without address or data port access, behaves as extended mode, pulsed interrupt.
// - ready held low beyond 10 us aborts the cycle by releasing ready.
// - time-out releases the active strobe and sets status bit 0.
// - with interrupt enable set, time-out pulses the port interrupt.
// - eight byte registers at offsets 0 to 7.
// - data write drives port lines; status read returns pins and interrupt status.
// - control write drives four control pins, interrupt enable and direction.
// - address register access starts an address write or read cycle.
// - data port 0 access starts a data cycle on bits 7 to 0.
// - data ports 1 to 3 carry upper bytes of wider accesses.
// - address write latches byte, drives lines, write line low, then strobe low.
// - wait low holds host ready low until wait rises.
// - write strobe rising releases strobe, then write line; data changes when both high.
// - address read gates port lines to host, strobe low, same wait handling.
// - read strobe rising releases strobe and floats host data on the same clock.
// - data cycles use data strobe and data registers instead.
// - zero-wait write with wait high asserts zero-wait request, ready stays high.
// - zero-wait end releases strobe, then request, then write line.
// - wait dropping before host ends pulls ready low, no zero-wait request.
// - zero-wait read mirrors write, write line stays high.
// - time-out flag cleared on mode enable, set by time-out, cleared by status read.
// - interrupt follows acknowledge or time-out when enabled, else floats.
`timescale 1ns/100ps
module epp_port
  import epp_pkg::*;
#(
  parameter int TIMEOUT_COUNT = TIMEOUT_CYCLES
) (
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic EPP_ENABLE,
  input wire logic [2:0] HOST_ADDR,
  input wire logic HOST_RD_N,
  input wire logic HOST_WR_N,
  input wire logic [7:0] HOST_DATA_IN,
  output logic [7:0] HOST_DATA_OUT,
  output logic HOST_DATA_OE_N,
  output logic HOST_READY_OUT,
  output logic HOST_READY_OE_N,
  output logic ZERO_WAIT_REQUEST_N,
  input wire logic [7:0] PORT_DATA_LINES_IN,
  output logic [7:0] PORT_DATA_LINES_OUT,
  output logic PORT_DATA_LINES_OE_N,
  output logic WRITE_DIR_N,
  output logic ADDRESS_STROBE_N,
  output logic DATA_STROBE_N,
  output logic STROBE_N,
  output logic AUTOFD_N,
  output logic INIT_N,
  output logic SELIN_N,
  input wire logic PORT_WAIT,
  input wire logic PORT_ACK_N,
  input wire logic PORT_ERROR_N,
  input wire logic PORT_SELECT,
  input wire logic PORT_PAPER_END,
  output logic PORT_INTERRUPT_MAIN,
  output logic PORT_INTERRUPT_OE_N
);
  initial begin
    if (TIMEOUT_COUNT < 2 || TIMEOUT_COUNT > 65535) begin
      $error("epp_port: TIMEOUT_COUNT out of range");
    end
  end

  epp_state_e state_ff;
  logic [7:0] data_ff, control_ff, address_ff;
  logic [7:0] xfer_ff [0:3];
  logic timeout_flag_ff, irq_stat_ff, ack_d_ff, en_d_ff;
  logic rd_d_ff, wr_d_ff;
  logic [15:0] tmo_cnt_ff;
  logic cyc_write_ff, cyc_addr_ff, cyc_zws_ff, cyc_tmo_ff;
  logic [1:0] cyc_lane_ff;
  logic [7:0] rd_data;
  logic rd_fall, wr_fall, rd_rise, wr_rise, epp_hit, host_end, tmo_hit, ack_rise;

  assign rd_fall = rd_d_ff && !HOST_RD_N;
  assign wr_fall = wr_d_ff && !HOST_WR_N;
  assign rd_rise = !rd_d_ff && HOST_RD_N;
  assign wr_rise = !wr_d_ff && HOST_WR_N;
  // address and data ports start peripheral cycles
  assign epp_hit = EPP_ENABLE && (HOST_ADDR >= OFS_ADDRESS);
  assign host_end = cyc_write_ff ? HOST_WR_N : HOST_RD_N;
  assign ack_rise = !ack_d_ff && PORT_ACK_N;
  assign tmo_hit = (state_ff == EPP_WAIT_END) && !HOST_READY_OE_N &&
                   (tmo_cnt_ff == 16'(TIMEOUT_COUNT - 1));

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      rd_d_ff <= 1'b1;
      wr_d_ff <= 1'b1;
      ack_d_ff <= 1'b1;
      en_d_ff <= 1'b0;
    end else begin
      rd_d_ff <= HOST_RD_N;
      wr_d_ff <= HOST_WR_N;
      ack_d_ff <= PORT_ACK_N;
      en_d_ff <= EPP_ENABLE;
    end
  end

  // plain register writes
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      data_ff <= DATA_RESET;
      control_ff <= CONTROL_RESET;
    end else if (wr_fall) begin
      if (HOST_ADDR == OFS_DATA) begin
        data_ff <= HOST_DATA_IN;
      end
      if (HOST_ADDR == OFS_CONTROL) begin
        control_ff <= HOST_DATA_IN;
      end
    end
  end

  // address and transfer byte latches
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      address_ff <= ADDRESS_RESET;
      for (int i = 0; i < 4; i++) begin
        xfer_ff[i] <= 8'h00;
      end
    end else if (wr_fall && epp_hit) begin
      if (HOST_ADDR == OFS_ADDRESS) begin
        address_ff <= HOST_DATA_IN;
      end else begin
        xfer_ff[HOST_ADDR[1:0]] <= HOST_DATA_IN;
      end
    end else if (state_ff == EPP_WAIT_END && !cyc_write_ff && !cyc_addr_ff) begin
      xfer_ff[cyc_lane_ff] <= PORT_DATA_LINES_IN;
    end
  end

  // peripheral cycle sequencer
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      state_ff <= EPP_IDLE;
      cyc_write_ff <= 1'b0;
      cyc_addr_ff <= 1'b0;
      cyc_zws_ff <= 1'b0;
      cyc_tmo_ff <= 1'b0;
      cyc_lane_ff <= 2'h0;
    end else begin
      case (state_ff)
        EPP_IDLE: begin
          if ((wr_fall || rd_fall) && epp_hit) begin
            cyc_write_ff <= wr_fall;
            cyc_addr_ff <= (HOST_ADDR == OFS_ADDRESS);
            cyc_lane_ff <= HOST_ADDR[1:0];
            cyc_zws_ff <= 1'b0;
            cyc_tmo_ff <= 1'b0;
            state_ff <= EPP_SETUP;
          end
        end
        EPP_SETUP: state_ff <= EPP_STROBE; // write line before strobe
        EPP_STROBE: begin
          cyc_zws_ff <= PORT_WAIT;
          state_ff <= EPP_WAIT_END;
        end
        EPP_WAIT_END: begin
          if (!PORT_WAIT) begin
            cyc_zws_ff <= 1'b0;
          end
          if (tmo_hit) begin
            cyc_tmo_ff <= 1'b1;
            state_ff <= EPP_REL_STB;
          end else if (host_end) begin
            state_ff <= EPP_REL_STB;
          end
        end
        EPP_REL_STB: state_ff <= cyc_zws_ff ? EPP_REL_ZWS : EPP_REL_DIR;
        EPP_REL_ZWS: state_ff <= EPP_REL_DIR;
        EPP_REL_DIR: begin
          if (host_end) begin
            state_ff <= EPP_IDLE;
          end
        end
        default: state_ff <= EPP_IDLE;
      endcase
    end
  end

  // time-out counter, restarted each cycle
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      tmo_cnt_ff <= 16'h0000;
    end else if (state_ff != EPP_WAIT_END) begin
      tmo_cnt_ff <= 16'h0000;
    end else if (!HOST_READY_OE_N && !tmo_hit) begin
      tmo_cnt_ff <= tmo_cnt_ff + 16'h0001;
    end
  end

  // status flags
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      timeout_flag_ff <= 1'b0;
      irq_stat_ff <= 1'b1;
    end else begin
      if (tmo_hit) begin
        timeout_flag_ff <= 1'b1; // set wins over clear
      end else if ((EPP_ENABLE && !en_d_ff) || (rd_rise && HOST_ADDR == OFS_STATUS)) begin
        timeout_flag_ff <= 1'b0;
      end
      if (control_ff[CT_IRQ_EN] && ack_rise) begin
        irq_stat_ff <= 1'b0;
      end else if (rd_rise && HOST_ADDR == OFS_STATUS) begin
        irq_stat_ff <= 1'b1;
      end
    end
  end

  always_comb begin
    rd_data = 8'h00;
    case (HOST_ADDR)
      OFS_DATA: rd_data = control_ff[CT_DIR] ? PORT_DATA_LINES_IN : data_ff;
      OFS_STATUS: rd_data = {!PORT_WAIT, PORT_ACK_N, PORT_PAPER_END, PORT_SELECT,
                             PORT_ERROR_N, irq_stat_ff, STATUS_FIXED_ONES[1],
                             EPP_ENABLE ? timeout_flag_ff : STATUS_FIXED_ONES[0]};
      OFS_CONTROL: rd_data = {2'h3, control_ff[5:0]};
      OFS_ADDRESS: rd_data = PORT_DATA_LINES_IN;
      default: rd_data = cyc_lane_ff == HOST_ADDR[1:0] ? PORT_DATA_LINES_IN
                         : xfer_ff[HOST_ADDR[1:0]];
    endcase
  end

  // host side outputs
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      HOST_DATA_OUT <= 8'h00;
      HOST_DATA_OE_N <= 1'b1;
      HOST_READY_OUT <= 1'b0;
      HOST_READY_OE_N <= 1'b1;
      ZERO_WAIT_REQUEST_N <= 1'b1;
    end else begin
      HOST_DATA_OUT <= rd_data;
      HOST_DATA_OE_N <= HOST_RD_N || (state_ff == EPP_REL_DIR);
      HOST_READY_OUT <= 1'b0;
      HOST_READY_OE_N <= !((state_ff == EPP_STROBE || state_ff == EPP_WAIT_END) &&
                           !PORT_WAIT && !tmo_hit && !cyc_tmo_ff);
      // request held through the strobe release edge, dropped one cycle later
      ZERO_WAIT_REQUEST_N <= !((state_ff == EPP_STROBE && PORT_WAIT) ||
                               (state_ff == EPP_WAIT_END && cyc_zws_ff &&
                                (PORT_WAIT || host_end)));
    end
  end

  // peripheral side outputs
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      PORT_DATA_LINES_OUT <= DATA_RESET;
      PORT_DATA_LINES_OE_N <= 1'b0;
      WRITE_DIR_N <= 1'b1;
      ADDRESS_STROBE_N <= 1'b1;
      DATA_STROBE_N <= 1'b1;
    end else begin
      if (state_ff == EPP_IDLE) begin
        PORT_DATA_LINES_OUT <= data_ff;
        PORT_DATA_LINES_OE_N <= control_ff[CT_DIR];
      end else if (state_ff == EPP_SETUP) begin
        PORT_DATA_LINES_OUT <= cyc_addr_ff ? address_ff : xfer_ff[cyc_lane_ff];
        PORT_DATA_LINES_OE_N <= !cyc_write_ff;
      end
      WRITE_DIR_N <= !(cyc_write_ff && state_ff != EPP_IDLE &&
                       state_ff != EPP_REL_DIR);
      ADDRESS_STROBE_N <= !(cyc_addr_ff && (state_ff == EPP_STROBE ||
                            (state_ff == EPP_WAIT_END && !host_end && !tmo_hit)));
      DATA_STROBE_N <= !(!cyc_addr_ff && (state_ff == EPP_STROBE ||
                         (state_ff == EPP_WAIT_END && !host_end && !tmo_hit)));
    end
  end

  // control pins and interrupt
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      STROBE_N <= 1'b1;
      AUTOFD_N <= 1'b1;
      INIT_N <= 1'b0;
      SELIN_N <= 1'b1;
      PORT_INTERRUPT_MAIN <= 1'b0;
      PORT_INTERRUPT_OE_N <= 1'b1;
    end else begin
      STROBE_N <= !control_ff[CT_STROBE];
      AUTOFD_N <= !control_ff[CT_AUTOFD];
      INIT_N <= control_ff[CT_INIT];
      SELIN_N <= !control_ff[CT_SELIN];
      PORT_INTERRUPT_MAIN <= tmo_hit || ack_rise;
      PORT_INTERRUPT_OE_N <= !control_ff[CT_IRQ_EN];
    end
  end

  a_timeout_release: assert property (@(posedge CORE_CLK) disable iff (RST)
    tmo_hit |=> HOST_READY_OE_N && ADDRESS_STROBE_N && DATA_STROBE_N)
    else $error("time-out did not release ready and strobes");
  a_timeout_flag: assert property (@(posedge CORE_CLK) disable iff (RST)
    tmo_hit |=> timeout_flag_ff)
    else $error("time-out flag not set");
  a_timeout_irq: assert property (@(posedge CORE_CLK) disable iff (RST)
    tmo_hit && control_ff[CT_IRQ_EN] |=> PORT_INTERRUPT_MAIN && !PORT_INTERRUPT_OE_N)
    else $error("time-out interrupt pulse missing");
  a_irq_pulse: assert property (@(posedge CORE_CLK) disable iff (RST)
    PORT_INTERRUPT_MAIN && !$past(PORT_INTERRUPT_MAIN) && !tmo_hit && !ack_rise
      |=> !PORT_INTERRUPT_MAIN)
    else $error("interrupt not a pulse");
  a_timeout_bound: assert property (@(posedge CORE_CLK) disable iff (RST)
    tmo_cnt_ff <= 16'(TIMEOUT_COUNT - 1))
    else $error("time-out counter overran");
  a_strobe_order: assert property (@(posedge CORE_CLK) disable iff (RST)
    $fell(ADDRESS_STROBE_N) && cyc_write_ff |-> !WRITE_DIR_N && $past(!WRITE_DIR_N))
    else $error("write line not low before strobe");
  a_dir_after_stb: assert property (@(posedge CORE_CLK) disable iff (RST)
    $rose(WRITE_DIR_N) |-> ADDRESS_STROBE_N && DATA_STROBE_N && $past(ADDRESS_STROBE_N)
      && $past(DATA_STROBE_N))
    else $error("write line released before strobe");
  a_zws_ready: assert property (@(posedge CORE_CLK) disable iff (RST)
    !ZERO_WAIT_REQUEST_N |-> HOST_READY_OE_N)
    else $error("zero-wait with ready low");
  a_ready_wait: assert property (@(posedge CORE_CLK) disable iff (RST)
    !HOST_READY_OE_N |-> $past(!PORT_WAIT))
    else $error("ready low while wait high");
  a_data_stable: assert property (@(posedge CORE_CLK) disable iff (RST)
    !ADDRESS_STROBE_N || !DATA_STROBE_N |-> $stable(PORT_DATA_LINES_OUT))
    else $error("port data changed under strobe");
  a_read_dir_high: assert property (@(posedge CORE_CLK) disable iff (RST)
    state_ff != EPP_IDLE && !cyc_write_ff |=> WRITE_DIR_N)
    else $error("write line low in read cycle");
endmodule // epp_port

//--- tb/epp_periph.sv
// peripheral model for the parallel port: wait handshake and read data
// assumes strobes and write line from the port block on the core clock
`timescale 1ns/100ps
module epp_periph (
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic [1:0] MODE,
  input wire logic ADDRESS_STROBE_N,
  input wire logic DATA_STROBE_N,
  input wire logic WRITE_DIR_N,
  input wire logic ZERO_WAIT_REQUEST_N,
  input wire logic [7:0] PORT_DATA_LINES_OUT,
  output logic PORT_WAIT,
  output logic [7:0] PORT_DATA_LINES_IN,
  output logic [7:0] SEEN_BYTE,
  output logic SEEN_DIR_N,
  output logic SEEN_DSTB,
  output logic [1:0] REL_ZWS_DIR
);
  logic [3:0] cnt_ff;
  logic [7:0] last_ff;
  logic stb_d_ff;
  logic stb_n;
  assign stb_n = ADDRESS_STROBE_N & DATA_STROBE_N;
  // mode 0 fast, 1 slow (three cycles), 2 stuck low
  assign PORT_WAIT = (MODE == 2'h0) | ((MODE == 2'h1) & (cnt_ff >= 4'h3));
  // read byte only while strobed for input, otherwise a changing pattern
  assign PORT_DATA_LINES_IN = (!stb_n & WRITE_DIR_N) ? 8'hC3 : ~last_ff;
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      cnt_ff <= 4'h0;
      last_ff <= 8'h00;
      stb_d_ff <= 1'b1;
    end else begin
      cnt_ff <= stb_n ? 4'h0 : (cnt_ff == 4'hF ? cnt_ff : cnt_ff + 4'h1);
      last_ff <= PORT_DATA_LINES_IN;
      stb_d_ff <= stb_n;
    end
  end
  // record what the port showed at strobe fall and strobe release
  always_ff @(posedge CORE_CLK) begin
    if (stb_d_ff & !stb_n) begin
      SEEN_BYTE <= PORT_DATA_LINES_OUT;
      SEEN_DIR_N <= WRITE_DIR_N;
      SEEN_DSTB <= !DATA_STROBE_N;
    end
    if (!stb_d_ff & stb_n) REL_ZWS_DIR <= {ZERO_WAIT_REQUEST_N, WRITE_DIR_N};
  end
endmodule // epp_periph

//--- tb/test_epp_port.sv
// testbench for the parallel port block: host register cycles, peripheral model
// assumes epp_pkg and the model in epp_periph.sv
`timescale 1ns/100ps
module test_epp_port;
  import epp_pkg::*;
  logic clk, rst, en, rd_n, wr_n, dout_oe_n, rdy_out, rdy_oe_n, zws_n;
  logic pout_oe_n, dir_n, astb_n, dstb_n, stb_n, afd_n, init_n, slin_n;
  logic pwait, irq, irq_oe_n, seen_dir, seen_d, rdy, rdy_lo, zws_lo, irq_hit;
  logic [2:0] addr;
  logic [7:0] din, dout, pin, pout, seen_b, q, v;
  logic [1:0] mode, rel;
  logic [5:0] op;
  int error_cnt, check_count, lo_cnt;
  assign rdy = rdy_oe_n ? 1'b1 : rdy_out;
  epp_port #(.TIMEOUT_COUNT(8)) i_dut (.CORE_CLK(clk), .RST(rst), .EPP_ENABLE(en),
    .HOST_ADDR(addr), .HOST_RD_N(rd_n), .HOST_WR_N(wr_n), .HOST_DATA_IN(din),
    .HOST_DATA_OUT(dout), .HOST_DATA_OE_N(dout_oe_n), .HOST_READY_OUT(rdy_out),
    .HOST_READY_OE_N(rdy_oe_n), .ZERO_WAIT_REQUEST_N(zws_n), .PORT_DATA_LINES_IN(pin),
    .PORT_DATA_LINES_OUT(pout), .PORT_DATA_LINES_OE_N(pout_oe_n), .WRITE_DIR_N(dir_n),
    .ADDRESS_STROBE_N(astb_n), .DATA_STROBE_N(dstb_n), .STROBE_N(stb_n),
    .AUTOFD_N(afd_n), .INIT_N(init_n), .SELIN_N(slin_n), .PORT_WAIT(pwait),
    .PORT_ACK_N(1'b1), .PORT_ERROR_N(1'b1), .PORT_SELECT(1'b1), .PORT_PAPER_END(1'b0),
    .PORT_INTERRUPT_MAIN(irq), .PORT_INTERRUPT_OE_N(irq_oe_n));
  epp_periph i_per (.CORE_CLK(clk), .RST(rst), .MODE(mode), .ADDRESS_STROBE_N(astb_n),
    .DATA_STROBE_N(dstb_n), .WRITE_DIR_N(dir_n), .ZERO_WAIT_REQUEST_N(zws_n),
    .PORT_DATA_LINES_OUT(pout), .PORT_WAIT(pwait), .PORT_DATA_LINES_IN(pin),
    .SEEN_BYTE(seen_b), .SEEN_DIR_N(seen_dir), .SEEN_DSTB(seen_d), .REL_ZWS_DIR(rel));
  initial begin
    clk = 0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    if (rdy !== 1'b1) lo_cnt++;
    if (rdy !== 1'b1) rdy_lo = 1;
    if (zws_n === 1'b0) zws_lo = 1;
    if (irq === 1'b1 && irq_oe_n === 1'b0) irq_hit = 1;
  end
  task automatic test_done;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one host cycle: hold strobe until ready is seen high
  task automatic xfer(input logic wr, input logic [2:0] a, input logic [7:0] d);
    int n;
    @(negedge clk);
    rdy_lo = 0;
    zws_lo = 0;
    lo_cnt = 0;
    addr = a;
    din = d;
    if (wr) wr_n = 0;
    else rd_n = 0;
    repeat (5) @(negedge clk);
    n = 0;
    while (rdy !== 1'b1 && n < 60) begin
      @(negedge clk);
      n++;
    end
    if (n == 60) begin
      error_cnt++;
      test_done();
    end
    q = dout;
    wr_n = 1;
    rd_n = 1;
    repeat (5) @(negedge clk);
  endtask
  initial begin
    rst = 1; en = 0; rd_n = 1; wr_n = 1; addr = 3'h0; din = 8'h00; mode = 2'h1;
    error_cnt = 0; check_count = 0; irq_hit = 0;
    repeat (12) @(negedge clk);
    rst = 0;
    @(negedge clk);
    en = 1;
    for (int i = 0; i < 2; i++) begin
      v = (i == 0) ? 8'h0B : 8'h14;
      xfer(1, OFS_CONTROL, v);
      chk("ctl pins", {4'h0, ~v[0], ~v[1], v[2], ~v[3]}, {4'h0, stb_n, afd_n, init_n, slin_n});
      chk("irq oe", {7'h0, ~v[4]}, {7'h0, irq_oe_n});
    end
    xfer(0, OFS_STATUS, 8'h00);
    chk("status", 8'hDE, q);
    xfer(1, OFS_DATA, 8'hA5);
    chk("port data", 8'hA5, pout);
    xfer(0, OFS_DATA, 8'h00);
    chk("data read", 8'hA5, q);
    // {write, wait mode, offset}
    for (int k = 0; k < 8; k++) begin
      op = (k == 0) ? 6'h2B : (k < 5) ? {3'b100, 3'(k + 3)} : (k == 5) ? 6'h0B : 6'h04 + 6'(k - 6) * 6'h02;
      mode = op[4:3];
      xfer(op[5], op[2:0], 8'h50 + 8'(k));
      chk("ready low", {7'h0, mode == 2'h1}, {7'h0, rdy_lo});
      chk("zws low", {7'h0, mode == 2'h0}, {7'h0, zws_lo});
      chk("release", {6'h0, mode == 2'h1, !op[5]}, {6'h0, rel});
      chk("dir at strobe", {7'h0, !op[5]}, {7'h0, seen_dir});
      chk("data strobe", {7'h0, op[2]}, {7'h0, seen_d});
      if (op[5]) chk("byte out", 8'h50 + 8'(k), seen_b);
      else chk("byte in", 8'hC3, q);
    end
    mode = 2'h2;
    irq_hit = 0;
    xfer(1, OFS_BYTE0, 8'h77);
    chk("ready window", 8'h01, {7'h0, lo_cnt >= 8 && lo_cnt <= 10});
    chk("strobes off", 8'h03, {6'h0, astb_n, dstb_n});
    chk("irq pulse", 8'h01, {7'h0, irq_hit});
    xfer(0, OFS_STATUS, 8'h00);
    chk("timeout set", 8'h01, {7'h0, q[ST_TIMEOUT]});
    xfer(0, OFS_STATUS, 8'h00);
    chk("timeout clr", 8'h00, {7'h0, q[ST_TIMEOUT]});
    test_done();
  end
endmodule // test_epp_port
